// >>> hw/bc_fault_event_interrupts.sv
/*
 * controller fault event interrupts: queue rollover, retry done, call depth
 * error and program trap, with pending, output enable, log and apb registers.
 * assumes a sequencer feeds one-cycle strobes on ref_clk and apb master.
 */
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`include "bc_fault_params.svh"

module bc_fault_event_interrupts
    import bc_fault_pkg::*;
#(
    parameter int QUEUE_WORDS = `QUEUE_WORDS,
    parameter int LOG_DEPTH = `LOG_DEPTH
) (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic startRun, // sequencer start request
    input wire logic queueWrite, // one word written to queue
    input wire logic retryDone, // final enabled retry finished
    input wire logic callOp, // call instruction executed
    input wire logic subroutine_return_op, // return instruction executed
    input wire logic fetchValid, // instruction fetched
    input wire logic opUndefined, // opcode is undefined
    input wire logic opParityBad, // instruction parity failed
    input wire logic [4:0] opField, // instruction bits 9-5
    input wire logic msgStart, // control word read
    input wire logic [2:0] ctrlFormat, // control word bits 2-0
    input wire logic [2:0] cmdFormat, // format decoded from command words
    input wire logic msgBusy, // message in progress
    input wire logic msgComplete, // message complete strobe
    output logic controller_running_flag, // sequencer may run
    output logic blockIs16, // message block length choice
    output logic useStoredCmd, // transmit stored command words
    output logic [5:0] queuePtr, // queue offset from base
    output logic irq, // host interrupt request pin
    output logic intOut // local sticky status interrupt
);
    // =====================================================
    // register state
    seq_state_t state_ff;
    logic [15:0] pending_ff;
    logic [15:0] outEn_ff;
    logic [15:0] config_ff;
    logic [15:0] status_ff;
    logic [15:0] enable_ff;
    logic [5:0] qptr_ff;
    logic irq_ff;
    logic [15:0] irqLatch_ff;
    logic [15:0] log_mem [LOG_DEPTH];
    logic [4:0] logPtr_ff;
    logic is16_ff;
    logic [31:0] prdata_ff;
    logic [2:0] depth;
    logic depthErr;
    seq_state_t nxt_state;

    // =====================================================
    // call depth tracking
    call_depth_counter #(.DEPTH_W(3)) u_depth (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .callOp(callOp),
        .returnOp(subroutine_return_op),
        .depth(depth),
        .depthError(depthErr)
    );

    // =====================================================
    // event detection
    wire qWrap = queueWrite && (qptr_ff == 6'(QUEUE_WORDS - 1));
    wire illegalOp = fetchValid && (opUndefined || opParityBad || opField != `OPFIELD_OK);
    wire fmtEnable = config_ff[`BIT_FMTCHK];
    wire fmtMismatch = msgStart && fmtEnable && (ctrlFormat != cmdFormat);
    wire running = (state_ff == SEQ_RUN) || (state_ff == SEQ_DRAIN);
    wire trapEvent = (illegalOp && running) || fmtMismatch;
    logic [15:0] rawEvents;
    always_comb begin
        rawEvents = 16'h0000;
        rawEvents[`BIT_QROLL] = qWrap;
        rawEvents[`BIT_RETRY] = retryDone;
        rawEvents[`BIT_CDEPTH] = depthErr;
        rawEvents[`BIT_TRAP] = trapEvent;
    end
    // pending only records events that software has enabled
    wire [15:0] enEvents = rawEvents & enable_ff;
    wire anyEvent = |enEvents;

    // =====================================================
    // sequencer run control: illegal op waits for the message to drain
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SEQ_IDLE: begin
                if (startRun) nxt_state = SEQ_RUN;
            end
            SEQ_RUN: begin
                if (illegalOp) nxt_state = msgBusy ? SEQ_DRAIN : SEQ_HALT;
            end
            SEQ_DRAIN: begin
                if (msgComplete || !msgBusy) nxt_state = SEQ_HALT;
            end
            SEQ_HALT: begin
                if (startRun) nxt_state = SEQ_RUN;
            end
            default: nxt_state = SEQ_IDLE;
        endcase
    end
    // format mismatch never touches the state, so running stays set
    assign controller_running_flag = (state_ff == SEQ_RUN) || (state_ff == SEQ_DRAIN);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) state_ff <= SEQ_IDLE;
        else state_ff <= nxt_state;
    end

    // =====================================================
    // message format handling: control bit 1 wins for rt-to-rt length
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) is16_ff <= 1'b0;
        else if (msgStart) is16_ff <= ctrlFormat[1];
    end
    assign blockIs16 = is16_ff;
    assign useStoredCmd = 1'b1;

    // =====================================================
    // queue pointer wraps modulo the queue size
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) qptr_ff <= 6'h00;
        else if (queueWrite) qptr_ff <= qWrap ? 6'h00 : qptr_ff + 6'h01;
    end
    assign queuePtr = qptr_ff;

    // =====================================================
    // apb decode: zero wait states, error on unmapped address
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hitPend = (paddr == `OFS_PENDING);
    wire hitOutEn = (paddr == `OFS_OUTEN);
    wire hitCfg = (paddr == `OFS_CONFIG);
    wire hitCc = (paddr == `OFS_CONDCODE);
    wire hitStat = (paddr == `OFS_STATUS);
    wire hitClr = (paddr == `OFS_CLEAR);
    wire hitEn = (paddr == `OFS_ENABLE);
    wire hitLog = (paddr == `OFS_LOGPTR);
    wire mapped = hitPend || hitOutEn || hitCfg || hitCc || hitStat || hitClr || hitEn || hitLog;
    wire pendRead = acc && !pwrite && hitPend;
    wire [15:0] ccValue = {controller_running_flag, 12'h000, depth};
    logic [31:0] rdMux;
    always_comb begin
        if (hitPend) rdMux = {16'h0000, pending_ff};
        else if (hitOutEn) rdMux = {16'h0000, outEn_ff};
        else if (hitCfg) rdMux = {16'h0000, config_ff};
        else if (hitCc) rdMux = {16'h0000, ccValue};
        else if (hitStat) rdMux = {16'h0000, status_ff};
        else if (hitEn) rdMux = {16'h0000, enable_ff};
        else if (hitLog) rdMux = {27'h0000000, logPtr_ff};
        else rdMux = 32'h00000000;
    end
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_ff;

    // read data is registered during setup so it stands at the access edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) prdata_ff <= 32'h00000000;
        else if (psel && !penable && !pwrite) prdata_ff <= rdMux;
    end

    // software registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            outEn_ff <= `RST_EVEN;
            config_ff <= `RST_CONFIG;
            enable_ff <= `RST_EVEN;
        end else if (wr) begin
            if (hitOutEn) outEn_ff <= pwdata[15:0];
            if (hitCfg) config_ff <= pwdata[15:0];
            if (hitEn) enable_ff <= pwdata[15:0];
        end
    end

    // =====================================================
    // pending: set wins over read-clear; only bits the host actually saw are
    // cleared, so an event landing between setup and access is not lost
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) pending_ff <= `RST_EVEN;
        else if (pendRead) pending_ff <= (pending_ff & ~prdata_ff[15:0]) | enEvents;
        else pending_ff <= pending_ff | enEvents;
    end

    // status: sticky, write-one-to-clear through the clear register, set wins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) status_ff <= `RST_EVEN;
        else if (wr && hitClr) status_ff <= (status_ff & ~pwdata[15:0]) | rawEvents;
        else status_ff <= status_ff | rawEvents;
    end
    assign intOut = |(status_ff & enable_ff);

    // =====================================================
    // interrupt log: one entry per cycle holding enabled events
    always_ff @(posedge ref_clk) begin
        if (anyEvent) log_mem[logPtr_ff] <= enEvents;
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) logPtr_ff <= 5'h00;
        else if (anyEvent) logPtr_ff <= logPtr_ff + 5'h01;
    end

    // =====================================================
    // irq: output-enabled events gathered, pin rises at message completion
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) irqLatch_ff <= `RST_EVEN;
        else if (msgComplete) irqLatch_ff <= 16'h0000;
        else irqLatch_ff <= irqLatch_ff | (enEvents & outEn_ff);
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) irq_ff <= 1'b0;
        else if (msgComplete && |(irqLatch_ff | (enEvents & outEn_ff))) irq_ff <= 1'b1;
        else if (pendRead) irq_ff <= 1'b0;
    end
    assign irq = irq_ff;
endmodule

// >>> hw/bc_fault_params.svh
/*
 * constants for the controller fault event block: offsets, bit positions,
 * reset values and sizes. assumes inclusion by bare name.
 */
`ifndef BC_FAULT_PARAMS_SVH
`define BC_FAULT_PARAMS_SVH

// =====================================================
// register byte offsets on the apb side
`define OFS_PENDING 12'h01C
`define OFS_OUTEN 12'h050
`define OFS_CONFIG 12'h0C8
`define OFS_CONDCODE 12'h0DC
`define OFS_STATUS 12'h100
`define OFS_CLEAR 12'h104
`define OFS_ENABLE 12'h108
`define OFS_LOGPTR 12'h10C

// =====================================================
// event and control bit positions
`define BIT_QROLL 13
`define BIT_RETRY 12
`define BIT_CDEPTH 11
`define BIT_TRAP 10
`define BIT_RUN 15
`define BIT_FMTCHK 13

// =====================================================
// reset values and sizes
`define RST_EVEN 16'h0000
`define RST_CONFIG 16'h0000
`define QUEUE_WORDS 64
`define CALL_DEPTH_MAX 3'h7
`define LOG_DEPTH 32
`define OPFIELD_OK 5'h00

`endif

// >>> hw/bc_fault_pkg.sv
/*
 * types for the controller fault event block.
 * assumes the params header is compiled alongside.
 */
package bc_fault_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_DRAIN = 2'b10,
        SEQ_HALT = 2'b11
    } seq_state_t;
endpackage

// >>> hw/call_depth_counter.sv
/*
 * subroutine call depth counter with overflow / underflow detection.
 * assumes call and return strobes are one-cycle pulses on ref_clk.
 */
`timescale 1ns/100ps
`include "bc_fault_params.svh"

module call_depth_counter #(
    parameter int DEPTH_W = 3
) (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic callOp, // call instruction executed
    input wire logic returnOp, // return instruction executed
    output logic [DEPTH_W-1:0] depth, // current depth
    output logic depthError // one-cycle error pulse
);
    logic [DEPTH_W-1:0] depth_ff;
    logic err_ff;
    logic [DEPTH_W-1:0] nxt_depth;
    wire atTop = (depth_ff == `CALL_DEPTH_MAX);
    wire atBottom = (depth_ff == '0);
    // =====================================================
    // next depth: saturate at the range ends instead of wrapping
    assign nxt_depth = (callOp && !atTop) ? depth_ff + 1'b1 :
                       (returnOp && !atBottom) ? depth_ff - 1'b1 :
                       depth_ff;
    wire nxtErr = (callOp && atTop) || (returnOp && atBottom);

    // depth register and error pulse
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            depth_ff <= '0;
            err_ff <= 1'b0;
        end else begin
            depth_ff <= nxt_depth;
            err_ff <= nxtErr;
        end
    end
    assign depth = depth_ff;
    assign depthError = err_ff;
endmodule

// >>> sim/bc_fault_checker_assertions.sv
/* port checker for the fault event block.
   assumes a bind from the bench top file and the single ref_clk domain. */
`timescale 1ns/100ps
module bc_fault_checker (
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // async reset
    input wire logic queueWrite, // queue word
    input wire logic fetchValid, // fetch strobe
    input wire logic opUndefined, // bad opcode
    input wire logic opParityBad, // bad parity
    input wire logic [4:0] opField, // op bits 9-5
    input wire logic msgStart, // control word read
    input wire logic [2:0] ctrlFormat, // control format
    input wire logic [2:0] cmdFormat, // command format
    input wire logic msgBusy, // message busy
    input wire logic msgComplete, // message done
    input wire logic controller_running_flag, // running
    input wire logic blockIs16, // block length
    input wire logic useStoredCmd, // stored words
    input wire logic [5:0] queuePtr, // queue offset
    input wire logic irq // interrupt pin
);
    // ==========
    // decode shared by the sequencer properties
    logic illegalOp;
    logic runFree;
    assign illegalOp = opUndefined | opParityBad | (opField != 5'h00);
    // a completion may end a pending drain, so it is kept out of the keep-running checks
    assign runFree = controller_running_flag & ~msgComplete;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_ptr_step: assert property (queueWrite |=> queuePtr == $past(queuePtr) + 6'h01)
        else $error("queue pointer did not step");
    a_ptr_hold: assert property (!queueWrite |=> $stable(queuePtr))
        else $error("queue pointer moved");
    a_trap_halt: assert property (fetchValid && illegalOp && runFree && !msgBusy |=> !controller_running_flag)
        else $error("illegal fetch did not halt");
    a_drain_run: assert property (fetchValid && illegalOp && runFree && msgBusy |=> controller_running_flag)
        else $error("halt before message end");
    a_legal_run: assert property (fetchValid && !illegalOp && runFree |=> controller_running_flag)
        else $error("legal fetch halted");
    a_fmt_run: assert property (msgStart && ctrlFormat != cmdFormat && runFree && !fetchValid |=> controller_running_flag)
        else $error("format mismatch halted");
    a_block_len: assert property (msgStart |=> blockIs16 == $past(ctrlFormat[1]))
        else $error("block length not from control bit 1");
    a_stored_cmd: assert property (useStoredCmd)
        else $error("stored command words not used");
    a_irq_cause: assert property ($rose(irq) |-> $past(msgComplete))
        else $error("irq rose without completion");
endmodule

// >>> sim/apb_host_model.sv
/* host side model: one apb master doing single transfers.
   assumes the caller is the bench top, and pready sampled at rising edges. */
`timescale 1ns/100ps
module apb_host_model (
    input wire logic ref_clk, // system clock
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction
    output logic [11:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    // ==========
    // idle bus shows inverted data so stale values never pass for fresh ones
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// >>> sim/tb_bc_fault_event_interrupts.sv
/* self-checking bench for the fault event block.
   assumes the params header, package, design and host model compile first. */
`timescale 1ns/100ps
`include "bc_fault_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_bc_fault_event_interrupts import bc_fault_pkg::*;;
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic startRun = 0, queueWrite = 0, retryDone = 0, callOp = 0, subroutine_return_op = 0, fetchValid = 0;
    logic opUndefined = 0, opParityBad = 0, msgStart = 0, msgBusy = 0, msgComplete = 0;
    logic [4:0] opField = 5'h00;
    logic [2:0] ctrlFormat = 3'h0, cmdFormat = 3'h0;
    logic controller_running_flag, blockIs16, useStoredCmd, irq, intOut;
    logic [5:0] queuePtr;
    int mismatches = 0, check_count = 0;
    // strobe codes, one bit per sequencer event
    localparam logic [7:0] ST = 8'h80, QW = 8'h40, RY = 8'h20, CL = 8'h10, RN = 8'h08, FE = 8'h04, MS = 8'h02, MC = 8'h01;
    always #2.5 ref_clk = ~ref_clk;
    apb_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bc_fault_event_interrupts uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .startRun(startRun), .queueWrite(queueWrite), .retryDone(retryDone), .callOp(callOp),
        .subroutine_return_op(subroutine_return_op), .fetchValid(fetchValid), .opUndefined(opUndefined),
        .opParityBad(opParityBad), .opField(opField), .msgStart(msgStart), .ctrlFormat(ctrlFormat),
        .cmdFormat(cmdFormat), .msgBusy(msgBusy), .msgComplete(msgComplete),
        .controller_running_flag(controller_running_flag), .blockIs16(blockIs16), .useStoredCmd(useStoredCmd),
        .queuePtr(queuePtr), .irq(irq), .intOut(intOut));
    // ==========
    // helpers
    function automatic logic [31:0] bitv(input int b);
        return 32'h1 << b;
    endfunction
    task pulse(input logic [7:0] v);
        @(posedge ref_clk);
        {startRun, queueWrite, retryDone, callOp, subroutine_return_op, fetchValid, msgStart, msgComplete} <= v;
        @(posedge ref_clk);
        {startRun, queueWrite, retryDone, callOp, subroutine_return_op, fetchValid, msgStart, msgComplete} <= 8'h00;
        // let the registered outputs settle before any caller compares them
        @(negedge ref_clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdv, err);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string n);
        host.xfer(1'b0, a, 32'h0, rdv, err);
        `CHK(n, e, rdv)
    endtask
    task tally_and_finish;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
    // ==========
    // main sequence
    initial begin
        void'($urandom(32'h72E59EBA));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`OFS_CONFIG, 32'h0, "config");
        rd(`OFS_OUTEN, 32'h0, "outen");
        rd(`OFS_PENDING, 32'h0, "pending");
        host.xfer(1'b0, 12'h200, 32'h0, rdv, err);
        `CHK("unmapped error", 1'b1, err)
        wr(`OFS_ENABLE, 32'h3C00);
        wr(`OFS_OUTEN, 32'h3C00);
        pulse(ST);
        repeat (63) pulse(QW);
        rd(`OFS_STATUS, 32'h0, "no early wrap");
        pulse(QW);
        `CHK("queue ptr", 6'h00, queuePtr)
        rd(`OFS_STATUS, bitv(13), "wrap event");
        wr(`OFS_CLEAR, 32'hFFFF);
        pulse(RY);
        rd(`OFS_STATUS, bitv(12), "retry event");
        wr(`OFS_CLEAR, 32'hFFFF);
        for (int i = 1; i < 8; i++) begin
            pulse(CL);
            rd(`OFS_CONDCODE, bitv(15) | i, "depth up");
        end
        rd(`OFS_STATUS, 32'h0, "no early overflow");
        pulse(CL);
        rd(`OFS_STATUS, bitv(11), "overflow");
        wr(`OFS_CLEAR, 32'hFFFF);
        for (int i = 6; i >= 0; i--) begin
            pulse(RN);
            rd(`OFS_CONDCODE, bitv(15) | i, "depth down");
        end
        pulse(RN);
        rd(`OFS_STATUS, bitv(11), "underflow");
        wr(`OFS_CLEAR, 32'hFFFF);
        // every control format, against a random differing command format, check off then on
        for (int k = 0; k < 16; k++) begin
            if (k == 8) wr(`OFS_CONFIG, bitv(13));
            ctrlFormat <= k[2:0];
            cmdFormat <= k[2:0] ^ 3'(1 + $urandom % 7);
            pulse(MS);
            `CHK("block length", k[1], blockIs16)
            `CHK("stored words", 1'b1, useStoredCmd)
            rd(`OFS_STATUS, (k < 8) ? 32'h0 : bitv(10), "format trap");
            rd(`OFS_CONDCODE, bitv(15), "format keeps run");
            wr(`OFS_CLEAR, 32'hFFFF);
        end
        pulse(MC);
        @(negedge ref_clk);
        `CHK("irq at completion", 1'b1, irq)
        rd(`OFS_PENDING, 32'h3C00, "pending bits");
        @(negedge ref_clk);
        `CHK("irq after read", 1'b0, irq)
        wr(`OFS_OUTEN, 32'h0);
        pulse(RY);
        pulse(MC);
        @(negedge ref_clk);
        `CHK("irq masked", 1'b0, irq)
        `CHK("local int", 1'b1, intOut)
        rd(`OFS_PENDING, bitv(12), "masked pending");
        wr(`OFS_ENABLE, 32'h0);
        pulse(RN);
        rd(`OFS_PENDING, 32'h0, "disabled event");
        wr(`OFS_ENABLE, 32'h3C00);
        wr(`OFS_CLEAR, 32'hFFFF);
        @(negedge ref_clk);
        `CHK("local int clear", 1'b0, intOut)
        wr(`OFS_CONFIG, 32'h0);
        pulse(FE);
        `CHK("legal fetch", 1'b1, controller_running_flag)
        // each illegal kind, fetched mid-message, keeps running until msgBusy drops
        for (int k = 0; k < 3; k++) begin
            pulse(ST);
            @(posedge ref_clk);
            msgBusy <= 1'b1;
            opUndefined <= (k == 0);
            opParityBad <= (k == 1);
            opField <= (k == 2) ? 5'(1 + $urandom % 31) : 5'h00;
            pulse(FE);
            repeat (3) @(posedge ref_clk);
            `CHK("drain run", 1'b1, controller_running_flag)
            msgBusy <= 1'b0;
            {opUndefined, opParityBad, opField} <= 7'h00;
            pulse(MC);
            @(negedge ref_clk);
            `CHK("halted", 1'b0, controller_running_flag)
            rd(`OFS_CONDCODE, 32'h0, "run flag cleared");
            rd(`OFS_STATUS, bitv(10), "illegal trap");
            wr(`OFS_CLEAR, 32'hFFFF);
        end
        tally_and_finish();
    end
endmodule
bind bc_fault_event_interrupts bc_fault_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .queueWrite(queueWrite),
    .fetchValid(fetchValid), .opUndefined(opUndefined), .opParityBad(opParityBad), .opField(opField),
    .msgStart(msgStart), .ctrlFormat(ctrlFormat), .cmdFormat(cmdFormat), .msgBusy(msgBusy),
    .msgComplete(msgComplete), .controller_running_flag(controller_running_flag), .blockIs16(blockIs16),
    .useStoredCmd(useStoredCmd), .queuePtr(queuePtr), .irq(irq));
